// [hw/ccs_core.sv]
// Control, status and fault reporting of a CAN protocol controller
// ***********************************************************************
// Overview of operation
// ***********************************************************************
module ccs_core (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic rxPin,
  input wire logic bitTick,
  input wire logic rxDone,
  input wire logic txDone,
  input wire logic faultValid,
  input wire ccs_pkg::ccs_fault_t faultCode,
  input wire logic txFault,
  input wire logic rxFault,
  input wire logic [15:0] msgIrqId,
  output logic txPin,
  output logic busActive,
  output logic retryEnable,
  output logic controllerIrq,
  output logic [14:0] timingOut
);
  import ccs_pkg::*;

  // ***********************************************************************
  // Registers
  // ***********************************************************************
  logic [7:0] ctl_q;
  logic [14:0] timing_q;
  logic [3:0] preExt_q;
  logic [5:0] test_q;
  logic rx_success_flag_q, tx_success_flag_q;
  logic [2:0] lfc_q;
  logic [7:0] tec_q;
  logic [6:0] rec_q;
  logic recPassive_q;
  logic busOff_q;
  logic warn_q;
  logic statusPend_q;
  ccs_rstate_t rs_q;
  logic [7:0] idleCnt_q;
  logic [3:0] recBits_q;
  logic wrCtl, wrSt, wrTim, wrPre, wrTst, rdSt;
  logic unlocked, warnNow, passiveNow, idleSeen, statusEvt, errEvt;
  logic recoveryDone, enterOff;
  logic [15:0] irqId;

  // Address decode
  assign wrCtl = regWrite && regAddr == CONTROL_OFS;
  assign wrSt = regWrite && regAddr == STATUS_OFS;
  assign wrTim = regWrite && regAddr == TIMING_OFS;
  assign wrPre = regWrite && regAddr == PRESCALE_EXT_OFS;
  assign wrTst = regWrite && regAddr == TEST_OFS;
  assign rdSt = regRead && regAddr == STATUS_OFS;

  // Timing unlock needs both bits set
  assign unlocked = ctl_q[CTL_UNLOCK] && ctl_q[CTL_HOLD];

  // Counter thresholds
  assign warnNow = tec_q >= WARN_LIMIT ||
                   {1'b0, rec_q} >= WARN_LIMIT;
  assign passiveNow = recPassive_q || tec_q >= PASSIVE_LIMIT;
  // A further error from the top band would overflow the counter
  assign enterOff = txFault && tec_q >= TEC_OFF_LIMIT && rs_q == RS_RUN;
  assign idleSeen = rs_q == RS_WAIT && bitTick && rxPin &&
                    recBits_q == IDLE_BITS - 4'd1;
  assign recoveryDone = idleSeen && idleCnt_q == IDLE_COUNT - 8'd1;

  // Interrupt events; software writes never count
  assign errEvt = ctl_q[CTL_ERRIE] &&
                  (enterOff || recoveryDone || warnNow != warn_q);
  assign statusEvt = ctl_q[CTL_SCIE] &&
                     (rxDone || txDone || faultValid || idleSeen);

  // Control register; bus-off forces the hold bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl_q <= CTL_RESET;
    end else if (enterOff) begin
      ctl_q[CTL_HOLD] <= 1'b1;
    end else if (wrCtl) begin
      ctl_q <= regWrData[7:0] & CTL_WMASK;
    end
  end

  // Timing registers guarded by the unlock pair
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timing_q <= TIMING_RESET;
      preExt_q <= PRESCALE_EXT_RESET;
    end else begin
      if (wrTim && unlocked) timing_q <= regWrData[14:0];
      if (wrPre && unlocked) preExt_q <= regWrData[3:0];
    end
  end

  // Test register writable only in diagnostic mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      test_q <= 6'h00;
    end else if (wrTst && ctl_q[CTL_DIAG]) begin
      // Field sits at bits 6:3 and is kept one place lower
      test_q <= regWrData[6:1] & TEST_WMASK;
    end
  end

  // Bus-off recovery sequence; hold toggles cannot skip it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rs_q <= RS_RUN;
      idleCnt_q <= 8'h00;
      recBits_q <= 4'h0;
      busOff_q <= 1'b0;
    end else begin
      case (rs_q)
        RS_RUN: begin
          if (enterOff) begin
            rs_q <= RS_OFF;
            busOff_q <= 1'b1;
          end
        end
        RS_OFF: begin
          // Counting starts only once software clears the hold
          if (!ctl_q[CTL_HOLD]) begin
            rs_q <= RS_WAIT;
            idleCnt_q <= 8'h00;
            recBits_q <= 4'h0;
          end
        end
        RS_WAIT: begin
          if (bitTick) begin
            if (!rxPin) begin
              recBits_q <= 4'h0;
            end else if (idleSeen) begin
              recBits_q <= 4'h0;
              idleCnt_q <= idleCnt_q + 8'd1;
            end else begin
              recBits_q <= recBits_q + 4'd1;
            end
          end
          if (recoveryDone) begin
            rs_q <= RS_RUN;
            busOff_q <= 1'b0;
          end
        end
        default: rs_q <= RS_RUN;
      endcase
    end
  end

  // Fault counters, reset at end of recovery
  always_ff @(posedge ref_clk) begin
    if (reset || recoveryDone) begin
      tec_q <= 8'h00;
      rec_q <= 7'h00;
      recPassive_q <= 1'b0;
    end else if (rs_q == RS_RUN) begin
      if (txFault && tec_q < TEC_OFF_LIMIT) tec_q <= tec_q + TEC_ERR_STEP;
      else if (txDone && tec_q != 8'h00) tec_q <= tec_q - 8'd1;
      if (rxFault) begin
        if (rec_q == REC_MAX) recPassive_q <= 1'b1;
        else rec_q <= rec_q + 7'd1;
      end else if (rxDone) begin
        if (recPassive_q) begin
          recPassive_q <= 1'b0;
          rec_q <= REC_RESUME;
        end else if (rec_q != 7'h00) begin
          rec_q <= rec_q - 7'd1;
        end
      end
    end
  end

  // Status fields; hardware set wins over software write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_success_flag_q <= 1'b0;
      tx_success_flag_q <= 1'b0;
      lfc_q <= LFC_NONE;
      warn_q <= 1'b0;
    end else begin
      warn_q <= warnNow;
      rx_success_flag_q <= rxDone | (wrSt ? regWrData[ST_RX_SUCCESS_FLAG] : rx_success_flag_q);
      tx_success_flag_q <= txDone | (wrSt ? regWrData[ST_TX_SUCCESS_FLAG] : tx_success_flag_q);
      if (idleSeen) lfc_q <= LFC_REC_SEEN;
      else if (faultValid) lfc_q <= faultCode;
      else if (rxDone || txDone) lfc_q <= LFC_NONE;
      else if (wrSt) lfc_q <= regWrData[2:0];
    end
  end

  // Pending status interrupt; a new event beats the read clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      statusPend_q <= 1'b0;
    end else if (errEvt || statusEvt) begin
      statusPend_q <= 1'b1;
    end else if (rdSt) begin
      statusPend_q <= 1'b0;
    end
  end

  assign irqId = statusPend_q ? IRQ_ID_STATUS : msgIrqId;

  // Outputs to the link side and interrupt controller
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      txPin <= 1'b1;
      busActive <= 1'b0;
      retryEnable <= 1'b1;
      controllerIrq <= 1'b0;
      timingOut <= TIMING_RESET;
    end else begin
      // Recessive whenever held or bus-off
      busActive <= !ctl_q[CTL_HOLD] && rs_q == RS_RUN;
      txPin <= 1'b1;
      retryEnable <= !ctl_q[CTL_NORETRY];
      controllerIrq <= irqId != IRQ_ID_NONE &&
                       ctl_q[CTL_MODIRQ];
      timingOut <= timing_q;
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regRdData <= 32'h0000_0000;
    end else if (regRead) begin
      case (regAddr)
        CONTROL_OFS: regRdData <= {24'h0, ctl_q};
        STATUS_OFS: regRdData <= {24'h0, busOff_q, warn_q, passiveNow,
                                  rx_success_flag_q, tx_success_flag_q, lfc_q};
        COUNTERS_OFS: regRdData <= {16'h0, recPassive_q, rec_q,
                                    tec_q};
        TIMING_OFS: regRdData <= {17'h0, timing_q};
        IRQ_ID_OFS: regRdData <= {16'h0, irqId};
        TEST_OFS: regRdData <= {24'h0, rxPin, test_q[5:2], 3'h0};
        PRESCALE_EXT_OFS: regRdData <= {28'h0, preExt_q};
        default: regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Register access guards and the retry output
  a_timing_locked: assert property (
    wrTim && !unlocked |=> $stable(timing_q))
    else $error("timing changed while locked");
  a_prescale_locked: assert property (
    wrPre && !unlocked |=> $stable(preExt_q))
    else $error("prescale changed while locked");
  a_test_locked: assert property (
    wrTst && !ctl_q[CTL_DIAG] |=> $stable(test_q))
    else $error("test register changed outside diagnostic mode");
  a_ctl_reserved: assert property (
    (ctl_q & ~CTL_WMASK) == 8'h00)
    else $error("reserved control bit set");
  a_no_retry: assert property (
    ctl_q[CTL_NORETRY] |=> !retryEnable)
    else $error("retry left enabled");

  // Bus-off entry and recovery
  a_busoff_hold: assert property (
    enterOff |=> ctl_q[CTL_HOLD] && busOff_q)
    else $error("bus-off did not set hold");
  a_offline_quiet: assert property (
    rs_q != RS_RUN |=> !busActive)
    else $error("bus active during bus-off");
  a_off_waits: assert property (
    rs_q == RS_OFF && ctl_q[CTL_HOLD] |=> rs_q == RS_OFF)
    else $error("recovery started while held");
  a_recov_length: assert property (
    rs_q == RS_WAIT && !recoveryDone |=> rs_q == RS_WAIT)
    else $error("recovery ended early");
  a_recov_clear: assert property (
    recoveryDone |=> tec_q == 8'h00 && rec_q == 7'h00)
    else $error("counters not cleared");
  a_idle_code: assert property (
    idleSeen |=> lfc_q == LFC_REC_SEEN)
    else $error("idle code missing");
  a_busoff_flag: assert property (
    busOff_q == (rs_q != RS_RUN))
    else $error("bus-off flag disagrees with state");

  // Status flags and fault code
  a_warn_flag: assert property (
    warnNow |=> warn_q)
    else $error("warning flag missing");
  a_rx_set: assert property (
    rxDone |=> rx_success_flag_q)
    else $error("receive flag not set");
  a_rx_sticky: assert property (
    rx_success_flag_q && !wrSt |=> rx_success_flag_q)
    else $error("receive flag cleared by core");
  a_tx_sticky: assert property (
    tx_success_flag_q && !wrSt |=> tx_success_flag_q)
    else $error("transmit flag cleared by core");
  a_code_clean: assert property (
    (rxDone || txDone) && !faultValid && !idleSeen |=> lfc_q == LFC_NONE)
    else $error("fault code not cleared");
  a_code_seven: assert property (
    lfc_q == LFC_UNUSED && !(idleSeen || faultValid || rxDone || txDone ||
    wrSt) |=> lfc_q == LFC_UNUSED)
    else $error("code seven overwritten without event");
  a_rx_passive: assert property (
    recPassive_q |-> rec_q == REC_MAX)
    else $error("passive bit below passive level");

  // Interrupts and bus outputs
  a_err_event: assert property (
    errEvt |=> statusPend_q)
    else $error("error change raised no interrupt");
  a_status_event: assert property (
    statusEvt |=> statusPend_q)
    else $error("status change raised no interrupt");
  a_no_irq_off: assert property (
    !ctl_q[CTL_ERRIE] && !ctl_q[CTL_SCIE] && !statusPend_q |=> !statusPend_q)
    else $error("interrupt while disabled");
  a_read_clears: assert property (
    rdSt && !errEvt && !statusEvt |=> !statusPend_q)
    else $error("status read kept pending");
  a_tx_recessive: assert property (
    ctl_q[CTL_HOLD] |=> txPin && !busActive)
    else $error("bus touched while held");
  a_irq_output: assert property (
    ##1 controllerIrq == ($past(irqId) != IRQ_ID_NONE &&
    $past(ctl_q[CTL_MODIRQ])))
    else $error("interrupt output wrong");

  // Main scenarios reached
  c_busoff: cover property (enterOff);
  c_recovery: cover property (recoveryDone);
  c_status_irq: cover property (statusPend_q ##1 rdSt);
  c_hold_toggle: cover property (rs_q == RS_WAIT && ctl_q[CTL_HOLD]);
  c_code_seven: cover property (lfc_q == LFC_UNUSED);
endmodule // ccs_core

// [hw/ccs_pkg.sv]
// Package of constants for the CAN core control and status block
package ccs_pkg;
  // Register byte offsets
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] COUNTERS_OFS = 8'h08;
  localparam logic [7:0] TIMING_OFS = 8'h0C;
  localparam logic [7:0] IRQ_ID_OFS = 8'h10;
  localparam logic [7:0] TEST_OFS = 8'h14;
  localparam logic [7:0] PRESCALE_EXT_OFS = 8'h18;
  // Control register fields
  localparam int CTL_HOLD = 0;
  localparam int CTL_MODIRQ = 1;
  localparam int CTL_SCIE = 2;
  localparam int CTL_ERRIE = 3;
  localparam int CTL_NORETRY = 5;
  localparam int CTL_UNLOCK = 6;
  localparam int CTL_DIAG = 7;
  localparam logic [7:0] CTL_WMASK = 8'hEF;
  localparam logic [7:0] CTL_RESET = 8'h01;
  // Status register fields
  localparam int ST_BUSOFF = 7;
  localparam int ST_WARN = 6;
  localparam int ST_PASSIVE = 5;
  localparam int ST_RX_SUCCESS_FLAG = 4;
  localparam int ST_TX_SUCCESS_FLAG = 3;
  // Register widths and reset values
  localparam logic [14:0] TIMING_RESET = 15'h2301;
  localparam logic [3:0] PRESCALE_EXT_RESET = 4'h0;
  localparam logic [5:0] TEST_WMASK = 6'h3C;
  localparam logic [15:0] IRQ_ID_STATUS = 16'h8000;
  localparam logic [15:0] IRQ_ID_NONE = 16'h0000;
  // Fault counter limits
  localparam logic [7:0] WARN_LIMIT = 8'd96;
  localparam logic [7:0] PASSIVE_LIMIT = 8'd128;
  // Steps of the chosen counter update law
  localparam logic [7:0] TEC_ERR_STEP = 8'h08;
  localparam logic [7:0] TEC_OFF_LIMIT = 8'hF8;
  localparam logic [6:0] REC_MAX = 7'h7F;
  localparam logic [6:0] REC_RESUME = 7'h77;
  // Bus-off recovery figures
  localparam logic [7:0] IDLE_COUNT = 8'd129;
  localparam logic [3:0] IDLE_BITS = 4'd11;
  // Last fault codes
  typedef enum logic [2:0] {
    LFC_NONE = 3'h0,
    LFC_STUFF = 3'h1,
    LFC_FORM = 3'h2,
    LFC_ACK = 3'h3,
    LFC_DOM_SEEN = 3'h4,
    LFC_REC_SEEN = 3'h5,
    LFC_CRC = 3'h6,
    LFC_UNUSED = 3'h7
  } ccs_fault_t;
  // Bus-off recovery state, one-hot
  typedef enum logic [2:0] {
    RS_RUN = 3'b001,
    RS_OFF = 3'b010,
    RS_WAIT = 3'b100
  } ccs_rstate_t;
endpackage

// [sim/ccs_bus_node.sv]
// Model of the far side of the bus: bit clock and bus level
module ccs_bus_node #(
  parameter int TICK_DIV = 2
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic busIdle,
  output logic rxPin,
  output logic bitTick
);
  timeunit 1ns;
  timeprecision 1ns;
  int divCnt;
  // ***********************************************
  // Bit clock and bus level
  // ***********************************************
  // A disturbed bus flips at every bit, so no recessive run can ever
  // reach the idle length and recovery cannot progress
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      divCnt <= 0;
      bitTick <= 1'b0;
      rxPin <= 1'b1;
    end else begin
      divCnt <= (divCnt == TICK_DIV - 1) ? 0 : divCnt + 1;
      bitTick <= (divCnt == TICK_DIV - 1);
      if (divCnt == TICK_DIV - 1) begin
        rxPin <= busIdle ? 1'b1 : ~rxPin;
      end
    end
  end
endmodule // ccs_bus_node

// [sim/tb.sv]
// Self-checking bench for the CAN core control and status block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ccs_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic rxDone = 1'b0;
  logic txDone = 1'b0;
  logic faultValid = 1'b0;
  logic txFault = 1'b0;
  logic rxFault = 1'b0;
  ccs_fault_t faultCode = LFC_NONE;
  logic [15:0] msgIrqId = 16'h0000;
  logic busIdle = 1'b1;
  logic [31:0] regRdData;
  logic rxPin;
  logic bitTick;
  logic txPin;
  logic busActive;
  logic retryEnable;
  logic controllerIrq;
  logic [14:0] timingOut;
  logic [31:0] rd;
  int errorCnt = 0;
  int nTests = 0;
  // Clock at 20 MHz
  always #25 ref_clk = ~ref_clk;
  ccs_core dut_u (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .rxPin(rxPin), .bitTick(bitTick),
    .rxDone(rxDone), .txDone(txDone), .faultValid(faultValid),
    .faultCode(faultCode), .txFault(txFault), .rxFault(rxFault),
    .msgIrqId(msgIrqId), .txPin(txPin), .busActive(busActive),
    .retryEnable(retryEnable), .controllerIrq(controllerIrq),
    .timingOut(timingOut));
  ccs_bus_node #(.TICK_DIV(2)) node_u (.ref_clk(ref_clk), .reset(reset),
    .busIdle(busIdle), .rxPin(rxPin), .bitTick(bitTick));
  // ***********************************************
  // Bus access and checking tasks
  // ***********************************************
  task automatic chk(input string what, input logic [31:0] got, exp);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 rd = regRdData;
  endtask
  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(w, rd, e);
  endtask
  // One-cycle bus event: 0 rx, 1 tx, 2 fault, 3 tx error, 4 rx error
  task automatic ev(input int k, input logic [2:0] c);
    @(posedge ref_clk);
    {rxDone, txDone, faultValid, txFault, rxFault} <= 5'b10000 >> k;
    faultCode <= ccs_fault_t'(c);
    @(posedge ref_clk);
    {rxDone, txDone, faultValid, txFault, rxFault} <= 5'b00000;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic wrap_up;
    if (errorCnt == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog so a stuck sequence still reaches the verdict
  initial begin
    repeat (100000) @(posedge ref_clk);
    errorCnt++;
    wrap_up;
  end
  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk("txPin", txPin, 1);
    chk("busActive", busActive, 0);
    rchk("control", CONTROL_OFS, 32'h01);
    rchk("status", STATUS_OFS, 0);
    rchk("counters", COUNTERS_OFS, 0);
    rchk("unmapped", 8'h20, 0);
    wr(TIMING_OFS, 32'h1234);
    rchk("timing locked", TIMING_OFS, 32'h2301);
    wr(CONTROL_OFS, 32'h41);
    wr(TIMING_OFS, 32'h1234);
    rchk("timing open", TIMING_OFS, 32'h1234);
    chk("timingOut", timingOut, 15'h1234);
    wr(TEST_OFS, 32'h78);
    rchk("test locked", TEST_OFS, 32'h80);
    wr(CONTROL_OFS, 32'h80);
    wr(TEST_OFS, 32'h78);
    rchk("test open", TEST_OFS, 32'hF8);
    wr(TEST_OFS, 0);
    chk("busActive run", busActive, 1);
    wr(CONTROL_OFS, 32'h2E);
    rchk("control", CONTROL_OFS, 32'h2E);
    chk("retryEnable", retryEnable, 0);
    ev(0, 0);
    chk("irq line", controllerIrq, 1);
    rchk("irq id rx", IRQ_ID_OFS, 32'h8000);
    rchk("status rx", STATUS_OFS, 32'h10);
    rchk("irq id read", IRQ_ID_OFS, 0);
    wr(STATUS_OFS, 0);
    rchk("irq id sw", IRQ_ID_OFS, 0);
    for (int c = 1; c < 7; c++) begin
      ev(2, c[2:0]);
      rchk("irq id fault", IRQ_ID_OFS, 32'h8000);
      rchk("fault code", STATUS_OFS, c);
    end
    ev(1, 0);
    rchk("clean tx", STATUS_OFS, 32'h08);
    wr(STATUS_OFS, 32'h0F);
    rchk("code seven", STATUS_OFS, 32'h0F);
    // Status changes now gated, error changes still enabled
    wr(CONTROL_OFS, 32'h0A);
    ev(0, 0);
    rchk("irq gated", IRQ_ID_OFS, 0);
    rchk("code cleared", STATUS_OFS, 32'h18);
    wr(STATUS_OFS, 0);
    repeat (12) ev(3, 0);
    rchk("irq warn", IRQ_ID_OFS, 32'h8000);
    rchk("warn", STATUS_OFS, 32'h40);
    rchk("tx count", COUNTERS_OFS, 32'h60);
    repeat (4) ev(3, 0);
    rchk("passive", STATUS_OFS, 32'h60);
    rchk("irq passive", IRQ_ID_OFS, 0);
    wr(STATUS_OFS, 32'hFFFFFFFF);
    rchk("status write", STATUS_OFS, 32'h7F);
    rchk("irq sw write", IRQ_ID_OFS, 0);
    wr(STATUS_OFS, 0);
    repeat (5) ev(4, 0);
    rchk("rx count", COUNTERS_OFS, 32'h0580);
    repeat (123) ev(4, 0);
    rdr(COUNTERS_OFS);
    chk("rx passive", rd[15], 1'b1);
    @(posedge ref_clk);
    msgIrqId <= 16'h0005;
    rchk("irq id msg", IRQ_ID_OFS, 32'h0005);
    chk("irq line msg", controllerIrq, 1);
    wr(CONTROL_OFS, 32'h08);
    rchk("control", CONTROL_OFS, 32'h08);
    chk("irq line off", controllerIrq, 0);
    @(posedge ref_clk);
    msgIrqId <= 16'h0000;
    busIdle <= 1'b0;
    // Drive the transmit counter into bus-off on a disturbed bus
    for (int i = 0; i < 40 && rd[7] !== 1'b1; i++) begin
      ev(3, 0);
      rdr(STATUS_OFS);
    end
    chk("bus-off", rd[7], 1'b1);
    rchk("hold set", CONTROL_OFS, 32'h09);
    chk("busActive off", busActive, 0);
    wr(CONTROL_OFS, 0);
    wr(CONTROL_OFS, 32'h01);
    wr(CONTROL_OFS, 0);
    @(posedge ref_clk);
    busIdle <= 1'b1;
    repeat (128 * 11 * 2) @(posedge ref_clk);
    rdr(STATUS_OFS);
    chk("still off", rd & 32'h87, 32'h85);
    for (int i = 0; i < 20 && rd[7] !== 1'b0; i++) begin
      rdr(STATUS_OFS);
    end
    chk("recovered", rd[7], 1'b0);
    rchk("counters zero", COUNTERS_OFS, 0);
    chk("busActive back", busActive, 1);
    wrap_up;
  end
endmodule // tb
